/* File: hw/ehtp_timer.v */
// enhanced timer: pwm, single pulse and capture input modes with an apb register slave
`timescale 1ns/1ps
`include "ehtp_regs.vh"

module ehtp_timer #(
   parameter TICK_DIV = `EHTP_TICK_DIV
) (
   // apb slave
   input  wire                    pclk,
   input  wire                    presetn,
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [`EHTP_ADDR_W-1:0] paddr,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output wire                    pready,
   output reg                     pslverr,
   // channel pins
   input  wire                    output_a_pin_i,
   output reg                     output_a_pin_o,
   output reg                     output_a_pin_oe,
   input  wire                    output_b_pin_i,
   output reg                     output_b_pin_o,
   output reg                     output_b_pin_oe,
   // trigger pin
   input  wire                    external_trigger_input
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg  [`EHTP_CTRL_W-1:0] ctrl_q;
   reg  [9:0]              cmpa_q;
   reg  [9:0]              cmpb_q;
   reg  [10:0]             cnt_q;
   reg                     down_q;
   reg                     run_prev_q;
   reg                     b_on_q;
   reg  [2:0]              evt_q;
   reg                     pin_a_prev_q;
   reg                     pin_b_prev_q;
   reg                     trig_prev_q;
   reg  [15:0]             div_q;

   wire                    run                 = ctrl_q[`EHTP_CTRL_RUN];
   wire [1:0]              pwm_alignment_select =
      ctrl_q[`EHTP_CTRL_ALIGN_HI:`EHTP_CTRL_ALIGN_LO];
   wire                    period_source_select = ctrl_q[`EHTP_CTRL_PSRC];
   wire [2:0]              period_code = ctrl_q[`EHTP_CTRL_PCODE_HI:`EHTP_CTRL_PCODE_LO];
   wire [1:0]              channel_a_mode_select =
      ctrl_q[`EHTP_CTRL_AMODE_HI:`EHTP_CTRL_AMODE_LO];
   wire [1:0]              channel_b_mode_select =
      ctrl_q[`EHTP_CTRL_BMODE_HI:`EHTP_CTRL_BMODE_LO];
   wire [1:0]              channel_a_pin_function = ctrl_q[`EHTP_CTRL_APF_HI:`EHTP_CTRL_APF_LO];
   wire [1:0]              channel_b_pin_function = ctrl_q[`EHTP_CTRL_BPF_HI:`EHTP_CTRL_BPF_LO];
   wire                    channel_a_initial_level   = ctrl_q[`EHTP_CTRL_AINIT];
   wire                    channel_b_initial_level   = ctrl_q[`EHTP_CTRL_BINIT];
   wire                    channel_a_polarity_invert = ctrl_q[`EHTP_CTRL_APOL];
   wire                    channel_b_polarity_invert = ctrl_q[`EHTP_CTRL_BPOL];
   wire                    trig_negative        = ctrl_q[`EHTP_CTRL_TRIG_NEG];

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   wire both_mode_pwm = (channel_a_mode_select == `EHTP_MODE_PWM) &&
                        (channel_b_mode_select == `EHTP_MODE_PWM);
   wire single_mode   = both_mode_pwm && (channel_a_pin_function == `EHTP_PF_SINGLE) &&
                        (channel_b_pin_function == `EHTP_PF_SINGLE);
   wire pwm_mode      = both_mode_pwm && !single_mode;
   wire cap_a_mode    = (channel_a_mode_select == `EHTP_MODE_CAPTURE);
   wire cap_b_mode    = (channel_b_mode_select == `EHTP_MODE_CAPTURE);
   wire capture_mode  = cap_a_mode || cap_b_mode;
   wire centre        = (pwm_alignment_select == `EHTP_ALIGN_CENTRE);

   ////////////////////////////////////////////////////////////////////////////
   // timer tick: prescaling is outside this block, a plain divider stands in
   wire tick = (div_q == TICK_DIV[15:0] - 16'h0001);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 16'h0000;
      end else if (tick) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // period arithmetic
   wire [10:0] code_x128  = {1'b0, period_code, 7'h00};
   wire [10:0] edge_period = period_source_select ? {1'b0, cmpa_q} :
                             ((period_code == 3'h0) ? `EHTP_EDGE_FULL : code_x128);
   // half period of the up/down ramp; whole period is twice this
   wire [10:0] centre_half = period_source_select ? {1'b0, cmpa_q} :
                             ((period_code == 3'h0) ? `EHTP_CENTRE_HALF : code_x128);
   wire [9:0]  cap_top     = (period_code == 3'h0) ? `EHTP_CAP_FULL :
                             code_x128[9:0];

   wire        run_rise  = run && !run_prev_q;
   wire        edge_wrap = (cnt_q + 11'h001 >= edge_period);
   wire        match_a   = (cnt_q == {1'b0, cmpa_q});
   wire        match_b   = (cnt_q == {1'b0, cmpb_q});
   wire        cap_wrap  = (cnt_q[9:0] == cap_top);

   ////////////////////////////////////////////////////////////////////////////
   // counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 11'h000;
         down_q <= 1'b0;
      end else if (run_rise) begin
         cnt_q  <= 11'h000;
         down_q <= 1'b0;
      end else if (run && tick) begin
         if (single_mode) begin
            cnt_q <= {1'b0, cnt_q[9:0] + 10'h001};           // no period limit
         end else if (capture_mode) begin
            cnt_q <= cap_wrap ? 11'h000 : {1'b0, cnt_q[9:0] + 10'h001};
         end else if (pwm_mode && centre) begin
            // ramp up to the half point, then down; runs even with pins forced
            if (!down_q) begin
               if (cnt_q + 11'h001 >= centre_half) begin
                  down_q <= 1'b1;
               end
               cnt_q <= cnt_q + 11'h001;
            end else if (cnt_q <= 11'h001) begin
               cnt_q  <= 11'h000;
               down_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 11'h001;
            end
         end else begin
            cnt_q <= edge_wrap ? 11'h000 : cnt_q + 11'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture edge detect; pins are taken as synchronous
   function cap_hit;
      input [1:0] pf;
      input       prev;
      input       now;
      begin
         case (pf)
            2'h0:    cap_hit = !prev && now;
            2'h1:    cap_hit = prev && !now;
            2'h2:    cap_hit = prev ^ now;
            default: cap_hit = 1'b0;
         endcase
      end
   endfunction

   wire cap_a = run && cap_a_mode &&
                cap_hit(channel_a_pin_function, pin_a_prev_q, output_a_pin_i);
   wire cap_b = run && cap_b_mode &&
                cap_hit(channel_b_pin_function, pin_b_prev_q, output_b_pin_i);

   wire trig_edge = trig_negative ? (trig_prev_q && !external_trigger_input) :
                                    (!trig_prev_q && external_trigger_input);

   ////////////////////////////////////////////////////////////////////////////
   // events
   // the count is stale on the restart cycle, so no match may be taken from it
   wire run_tick = run && !run_rise && tick;
   wire ev_a = run_tick && (single_mode || pwm_mode) && match_a;
   wire ev_b = run_tick && (single_mode || pwm_mode) && match_b;
   wire ev_p = run_tick && !period_source_select && pwm_mode &&
               (centre ? (down_q && cnt_q == 11'h001) : edge_wrap);
   wire ev_cp = run_tick && capture_mode && cap_wrap;

   wire [2:0] evt_set = {ev_p || ev_cp, ev_b || cap_b, ev_a || cap_a};

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait, read data captured in the setup cycle
   wire setup   = psel && !penable;
   wire wr_acc  = psel && penable && pwrite;
   wire mapped  = (paddr == `EHTP_OFS_CTRL) || (paddr == `EHTP_OFS_CMPA) ||
                  (paddr == `EHTP_OFS_CMPB) || (paddr == `EHTP_OFS_COUNT) ||
                  (paddr == `EHTP_OFS_EVENT);
   assign pready = 1'b1;

   reg [31:0] rd_mux;
   always @* begin
      case (paddr)
         `EHTP_OFS_CTRL:  rd_mux = {{(32-`EHTP_CTRL_W){1'b0}}, ctrl_q};
         `EHTP_OFS_CMPA:  rd_mux = {22'h0, cmpa_q};
         `EHTP_OFS_CMPB:  rd_mux = {22'h0, cmpb_q};
         `EHTP_OFS_COUNT: rd_mux = {21'h0, cnt_q};
         `EHTP_OFS_EVENT: rd_mux = {29'h0, evt_q};
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= !mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control, compare and event registers
   wire wr_ctrl = wr_acc && (paddr == `EHTP_OFS_CTRL);
   wire wr_cmpa = wr_acc && (paddr == `EHTP_OFS_CMPA);
   wire wr_cmpb = wr_acc && (paddr == `EHTP_OFS_CMPB);
   wire wr_evt  = wr_acc && (paddr == `EHTP_OFS_EVENT);

   reg [`EHTP_CTRL_W-1:0] ctrl_d;
   always @* begin
      ctrl_d = wr_ctrl ? pwdata[`EHTP_CTRL_W-1:0] : ctrl_q;
      // hardware set and clear of run win over a software write in the same cycle
      if (single_mode && trig_edge) begin
         ctrl_d[`EHTP_CTRL_RUN] = 1'b1;
      end
      if (single_mode && ev_a) begin
         ctrl_d[`EHTP_CTRL_RUN] = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q       <= `EHTP_CTRL_RST;
         cmpa_q       <= 10'h000;
         cmpb_q       <= 10'h000;
         evt_q        <= 3'h0;
         run_prev_q   <= 1'b0;
         pin_a_prev_q <= 1'b0;
         pin_b_prev_q <= 1'b0;
         trig_prev_q  <= 1'b0;
      end else begin
         ctrl_q       <= ctrl_d;
         run_prev_q   <= run;
         pin_a_prev_q <= output_a_pin_i;
         pin_b_prev_q <= output_b_pin_i;
         trig_prev_q  <= external_trigger_input;
         // a capture landing with a software write keeps the captured value
         if (cap_a) begin
            cmpa_q <= cnt_q[9:0];
         end else if (wr_cmpa) begin
            cmpa_q <= pwdata[9:0];
         end
         if (cap_b) begin
            cmpb_q <= cnt_q[9:0];
         end else if (wr_cmpb) begin
            cmpb_q <= pwdata[9:0];
         end
         // write one to clear; a new event in the same cycle stays set
         evt_q <= (evt_q & ~(wr_evt ? pwdata[2:0] : 3'h0)) | evt_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // single pulse channel B latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_on_q <= 1'b0;
      end else if (!run || run_rise) begin
         b_on_q <= 1'b0;
      end else if (single_mode && ev_b) begin
         b_on_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // waveform and pins
   // raw activity of each channel before level shaping
   wire [10:0] duty_a = {1'b0, cmpa_q};
   wire [10:0] duty_b = {1'b0, cmpb_q};
   // cnt never reaches the period, so a duty at or above it stays active
   wire pwm_a = run && (cnt_q < duty_a);
   wire pwm_b = run && (cnt_q < duty_b);
   wire sp_a  = run;
   wire sp_b  = run && b_on_q;

   // initial level picks the active level, polarity flips the result
   wire wave_a = ((single_mode ? sp_a : pwm_a) ? channel_a_initial_level :
                  !channel_a_initial_level) ^ channel_a_polarity_invert;
   wire wave_b = ((single_mode ? sp_b : pwm_b) ? channel_b_initial_level :
                  !channel_b_initial_level) ^ channel_b_polarity_invert;

   reg pin_a_d;
   reg pin_b_d;
   always @* begin
      case (channel_a_pin_function)
         `EHTP_PF_LOW:  pin_a_d = 1'b0;
         `EHTP_PF_HIGH: pin_a_d = 1'b1;
         default:       pin_a_d = wave_a;
      endcase
      case (channel_b_pin_function)
         `EHTP_PF_LOW:  pin_b_d = 1'b0;
         `EHTP_PF_HIGH: pin_b_d = 1'b1;
         default:       pin_b_d = wave_b;
      endcase
   end

   // capture channels never drive, so their own pin cannot fake an edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_a_pin_o  <= 1'b0;
         output_a_pin_oe <= 1'b0;
         output_b_pin_o  <= 1'b0;
         output_b_pin_oe <= 1'b0;
      end else begin
         output_a_pin_o  <= cap_a_mode ? 1'b0 : pin_a_d;
         output_a_pin_oe <= both_mode_pwm && !cap_a_mode;
         output_b_pin_o  <= cap_b_mode ? 1'b0 : pin_b_d;
         output_b_pin_oe <= both_mode_pwm && !cap_b_mode;
      end
   end

endmodule // ehtp_timer

/* File: shared/ehtp_regs.vh */
// register offsets, field positions, reset values and counts for the enhanced timer
`ifndef EHTP_REGS_VH
`define EHTP_REGS_VH

`define EHTP_ADDR_W        8
`define EHTP_OFS_CTRL      8'h00
`define EHTP_OFS_CMPA      8'h04
`define EHTP_OFS_CMPB      8'h08
`define EHTP_OFS_COUNT     8'h0C
`define EHTP_OFS_EVENT     8'h10

`define EHTP_CTRL_RUN      0
`define EHTP_CTRL_ALIGN_LO 1
`define EHTP_CTRL_ALIGN_HI 2
`define EHTP_CTRL_PSRC     3
`define EHTP_CTRL_PCODE_LO 4
`define EHTP_CTRL_PCODE_HI 6
`define EHTP_CTRL_AMODE_LO 7
`define EHTP_CTRL_AMODE_HI 8
`define EHTP_CTRL_BMODE_LO 9
`define EHTP_CTRL_BMODE_HI 10
`define EHTP_CTRL_APF_LO   11
`define EHTP_CTRL_APF_HI   12
`define EHTP_CTRL_BPF_LO   13
`define EHTP_CTRL_BPF_HI   14
`define EHTP_CTRL_AINIT    15
`define EHTP_CTRL_BINIT    16
`define EHTP_CTRL_APOL     17
`define EHTP_CTRL_BPOL     18
`define EHTP_CTRL_TRIG_NEG 19
`define EHTP_CTRL_W        20
`define EHTP_CTRL_RST      20'h00000

`define EHTP_EVT_A         0
`define EHTP_EVT_B         1
`define EHTP_EVT_P         2

`define EHTP_MODE_CAPTURE  2'h1
`define EHTP_MODE_PWM      2'h2
`define EHTP_PF_LOW        2'h0
`define EHTP_PF_HIGH       2'h1
`define EHTP_PF_ACTIVE     2'h2
`define EHTP_PF_SINGLE     2'h3
`define EHTP_ALIGN_CENTRE  2'h3

`define EHTP_EDGE_FULL     11'h400
`define EHTP_CENTRE_HALF   11'h3FF
`define EHTP_CAP_FULL      10'h3FF
`define EHTP_TICK_DIV      1

`endif

/* File: test/ehtp_checker.sv */
// checker: pin drive and apb answer relations of the enhanced timer
`timescale 1ns/1ps
module ehtp_checker (
   // apb side
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // channel pins
   input wire        output_a_pin_o,
   input wire        output_a_pin_oe,
   input wire        output_b_pin_o,
   input wire        output_b_pin_oe
);
   // shadow of the control word; the run bit is left out since hardware moves it
   reg  [19:0] sh_q;
   wire        acc   = psel && penable;
   wire        bad   = paddr > 8'h10 || paddr[1:0] != 2'h0;
   wire        pwm   = sh_q[8:7] == 2'h2 && sh_q[10:9] == 2'h2;
   wire        cap_a = sh_q[8:7] == 2'h1;
   wire        cap_b = sh_q[10:9] == 2'h1;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) sh_q <= 20'h00000;
      else if (acc && pwrite && paddr == 8'h00) sh_q <= {pwdata[19:1], 1'b0};
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pins lag the control word by one register, so the word must have settled
   property p_cap_a_quiet; cap_a && $stable(sh_q) |-> !output_a_pin_oe; endproperty
   property p_cap_b_quiet; cap_b && $stable(sh_q) |-> !output_b_pin_oe; endproperty
   property p_force_a_low;
      pwm && sh_q[12:11] == 2'h0 && $stable(sh_q) |-> output_a_pin_oe && !output_a_pin_o;
   endproperty
   property p_force_b_high;
      pwm && sh_q[14:13] == 2'h1 && $stable(sh_q) |-> output_b_pin_oe && output_b_pin_o;
   endproperty
   property p_ready; acc |-> pready; endproperty
   property p_slverr; acc && bad |-> pslverr; endproperty
   property p_no_err; acc && !bad |-> !pslverr; endproperty
   property p_rd_zero; acc && !pwrite && bad |-> prdata == 32'h00000000; endproperty
   a_cap_a_quiet: assert property (p_cap_a_quiet) else $error("pin a driven in capture");
   a_cap_b_quiet: assert property (p_cap_b_quiet) else $error("pin b driven in capture");
   a_force_a_low: assert property (p_force_a_low) else $error("pin a not forced low");
   a_force_b_high: assert property (p_force_b_high) else $error("pin b not forced high");
   a_ready: assert property (p_ready) else $error("access without ready");
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   a_no_err: assert property (p_no_err) else $error("mapped access refused");
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
   c_refused: cover property (acc && bad);
   c_pwm_b: cover property (pwm && output_b_pin_oe && output_b_pin_o);
   c_capture: cover property (cap_a && acc);
endmodule // ehtp_checker

bind ehtp_timer ehtp_checker u_ehtp_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .output_a_pin_o, .output_a_pin_oe, .output_b_pin_o,
   .output_b_pin_oe);

/* File: test/ehtp_pin_partner.sv */
// pin side partner: resolved channel pin wires and the trigger pin
`timescale 1ns/1ps
module ehtp_pin_partner (
   // clock
   input  wire pclk,
   // timer side of the channel pins
   input  wire a_o,
   input  wire a_oe,
   input  wire b_o,
   input  wire b_oe,
   // pin levels and trigger
   output wire a_lv,
   output wire b_lv,
   output reg  trig
);
   reg drv_q;
   initial begin
      trig  = 1'b0;
      drv_q = 1'b0;
   end
   // external source only shows through while the timer lets go of the pin
   assign a_lv = a_oe ? a_o : drv_q;
   assign b_lv = b_oe ? b_o : drv_q;
   // one cycle is enough: the trigger pin is sampled every clock
   task trigger;
      @(posedge pclk);
      trig <= 1'b1;
      @(posedge pclk);
      trig <= 1'b0;
   endtask
   // a pulse carries both edge kinds, whatever edge the channel waits
   task pulse;
      @(posedge pclk);
      drv_q <= 1'b1;
      repeat (3) @(posedge pclk);
      drv_q <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule // ehtp_pin_partner

/* File: test/test_enhanced_timer_pwm_pulse_capture.sv */
// testbench of the enhanced timer: pwm, single pulse and capture modes
`timescale 1ns/1ps
`include "ehtp_regs.vh"
module test_enhanced_timer_pwm_pulse_capture;
   reg          pclk, presetn, psel, penable, pwrite;
   reg  [7:0]   paddr;
   reg  [31:0]  pwdata;
   wire [31:0]  prdata;
   wire         pready, pslverr, a_o, a_oe, b_o, b_oe, a_lv, b_lv, trig;
   int          miscompares, cmp_count, cyc, i, ha, hb, w0, w1, al, s, code, p, a, b;
   logic [31:0] r, r2;
   logic        err;
   ehtp_timer #(.TICK_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .output_a_pin_i(a_lv), .output_a_pin_o(a_o),
      .output_a_pin_oe(a_oe), .output_b_pin_i(b_lv), .output_b_pin_o(b_o),
      .output_b_pin_oe(b_oe), .external_trigger_input(trig));
   ehtp_pin_partner pins (.pclk(pclk), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
      .a_lv(a_lv), .b_lv(b_lv), .trig(trig));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64) miscompares++;
      r       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task cnt(input int n);
      ha = 0;
      hb = 0;
      repeat (n) begin
         @(posedge pclk);
         ha += (a_o === 1'b1);
         hb += (b_o === 1'b1);
      end
   endtask
   // both initial levels high, so an active pin reads high unless inverted
   function logic [31:0] mk(input int al, s, code, md, pa, pb, pol);
      return al << 1 | s << 3 | code << 4 | md << 7 | md << 9 | pa << 11 | pb << 13
             | 3 << 15 | pol << 17 | pol << 18;
   endfunction
   function int per(input int c, s, code, a);
      if (s) return c ? 2 * a : a;
      if (code == 0) return c ? 2046 : 1024;
      return c ? 256 * code : 128 * code;
   endfunction
   function int duty(input int c, cm, pd);
      int d;
      d = c ? 2 * cm - 1 : cm;
      return d >= pd ? pd : d;
   endfunction
   // one whole period of samples holds exactly one duty, whatever the phase
   task pwm(input int pol);
      int c;
      c = al == 3;
      p = per(c, s, code, a);
      apb(1, `EHTP_OFS_CMPA, a);
      apb(1, `EHTP_OFS_CMPB, b);
      apb(1, `EHTP_OFS_EVENT, 7);
      apb(1, `EHTP_OFS_CTRL, mk(al, s, code, 2, s ? 0 : 2, 2, pol) | 1);
      repeat (8) @(posedge pclk);
      cnt(p);
      if (!s) chk("duty a", pol ? p - duty(c, a, p) : duty(c, a, p), ha);
      chk("duty b", pol ? p - duty(c, b, p) : duty(c, b, p), hb);
      apb(0, `EHTP_OFS_EVENT, 0);
      chk("period event", !s, r[2]);
      apb(1, `EHTP_OFS_CTRL, 0);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      cyc = 0;
      forever begin
         @(posedge pclk);
         cyc++;
         if (cyc == 90000) begin
            miscompares++;
            give_verdict();
         end
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      miscompares = 0;
      cmp_count = 0;
      void'($urandom(59));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(0, {i[5:0], 2'b00}, 0);
         chk("reset value", 0, r);
      end
      apb(0, 8'h14, 32'hFFFFFFFF);
      chk("unmapped refused", 1, err);
      // corners first: duty beyond period on each alignment, then random settings
      for (i = 0; i < 10; i++) begin
         al = i == 1 ? 3 : i == 0 ? 0 : ($urandom % 2 ? 3 : $urandom % 3);
         s = i > 1 && $urandom % 2;
         code = i < 2 ? 1 : $urandom % 8;
         p = per(al == 3, 0, code, 0);
         a = i < 2 ? 1000 : s ? 8 + $urandom % 1000 : 1 + $urandom % (al == 3 ? p / 2 - 2 : 1023);
         b = i < 2 ? 64 : s ? 1 + $urandom % (a - 4) : 1 + $urandom % (al == 3 ? p / 2 - 2 : 1023);
         pwm(i % 2);
      end
      apb(1, `EHTP_OFS_CTRL, mk(0, 0, 1, 2, 0, 1, 0) | 1);
      // pins trail the control word by one register
      @(posedge pclk);
      cnt(20);
      chk("forced a", 0, ha);
      chk("forced b", 20, hb);
      apb(0, `EHTP_OFS_COUNT, 0);
      r2 = r;
      apb(0, `EHTP_OFS_COUNT, 0);
      chk("count runs", 1, r != r2);
      apb(1, `EHTP_OFS_CTRL, 0);
      apb(1, `EHTP_OFS_EVENT, 7);
      apb(1, `EHTP_OFS_CMPA, 40);
      apb(1, `EHTP_OFS_CMPB, 10);
      apb(1, `EHTP_OFS_CTRL, mk(0, 0, 0, 2, 3, 3, 0));
      pins.trigger();
      cnt(120);
      w0 = ha;
      w1 = hb;
      apb(0, `EHTP_OFS_CTRL, 0);
      chk("run cleared", 0, r[0]);
      apb(0, `EHTP_OFS_EVENT, 0);
      chk("pulse events", 3, r[2:0]);
      apb(0, `EHTP_OFS_COUNT, 0);
      r2 = r;
      apb(0, `EHTP_OFS_COUNT, 0);
      chk("count held", r2, r);
      apb(1, `EHTP_OFS_CMPA, 60);
      apb(1, `EHTP_OFS_CMPB, 30);
      apb(1, `EHTP_OFS_CTRL, mk(0, 0, 0, 2, 3, 3, 0) | 1);
      cnt(120);
      chk("width a", w0 + 20, ha);
      chk("width b", w1, hb);
      apb(1, `EHTP_OFS_CTRL, 0);
      apb(1, `EHTP_OFS_CMPA, 32'h3FF);
      apb(1, `EHTP_OFS_CMPB, 32'h155);
      apb(1, `EHTP_OFS_EVENT, 7);
      apb(1, `EHTP_OFS_CTRL, mk(0, 1, 1, 1, 0, 3, 1) | 1);
      cnt(300);
      pins.pulse();
      apb(0, `EHTP_OFS_EVENT, 0);
      chk("capture events", 5, r[2:0]);
      apb(0, `EHTP_OFS_CMPA, 0);
      chk("captured", 1, r <= 128);
      apb(0, `EHTP_OFS_CMPB, 0);
      chk("no capture b", 32'h155, r);
      apb(0, `EHTP_OFS_COUNT, 0);
      r2 = r;
      apb(0, `EHTP_OFS_COUNT, 0);
      chk("free run", 1, r != r2 && r <= 128);
      give_verdict();
   end
endmodule // test_enhanced_timer_pwm_pulse_capture
